// File: hw/tmr8_clksel.sv
`timescale 1ns/1ns
`default_nettype none
`include "tmr8_regs.svh"
// Picks the tick source and divides it down through a ten bit prescaler.
module tmr8_clksel (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic xtal_in,
    input wire logic async_sel,
    input wire logic [2:0] clk_sel,
    output logic xtal_drive,
    tmr8_tick_if.clk_src bus
);
    tmr8_pkg::tmr8_clk_type q, n; // Registered state and its next value.
    logic base; // One base tick of the selected source.
    logic [9:0] tap; // Prescaler mask for the selected division.

    // Decodes a clock select code into a prescaler tap mask.
    function automatic logic [9:0] tap_mask(input logic [2:0] cs);
        case (cs)
            3'h1: return `TMR8_TAP_1;
            3'h2: return `TMR8_TAP_8;
            3'h3: return `TMR8_TAP_32;
            3'h4: return `TMR8_TAP_64;
            3'h5: return `TMR8_TAP_128;
            3'h6: return `TMR8_TAP_256;
            default: return `TMR8_TAP_1024;
        endcase
    endfunction : tap_mask

    // The crystal pin is sampled twice before its edge is looked at.
    always_comb
    begin
        n = q;
        n.xtal_sync = {q.xtal_sync[0], xtal_in};
        n.xtal_last = q.xtal_sync[1];
        // The oscillator amplifier only runs while the crystal is in use.
        n.drive = async_sel & ~q.xtal_sync[1];
        base = async_sel ? (q.xtal_sync[1] & ~q.xtal_last) : 1'b1;
        tap = tap_mask(clk_sel);
        bus.tick = 1'b0;
        if ((clk_sel != 3'h0) && base)
        begin
            n.pre = q.pre + 10'h001;
            bus.tick = (q.pre & tap) == tap;
        end
    end

    // Registers the state.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

    assign xtal_drive = q.drive;

    a_stop_no_tick: assert property (@(posedge clk) disable iff (!rst_n)
        (clk_sel == 3'h0) |-> !bus.tick) else $error("tick while stopped");
    a_io_full_rate: assert property (@(posedge clk) disable iff (!rst_n)
        (!async_sel && clk_sel == 3'h1) |-> bus.tick) else $error("io tick lost");
endmodule : tmr8_clksel
`default_nettype wire

// File: hw/tmr8_pkg.sv
`default_nettype none
package tmr8_pkg;
    // Waveform generation modes, in control register encoding order.
    typedef enum logic [1:0] {mode_normal, mode_pwm_pc, mode_ctc, mode_pwm_fast} tmr8_mode_type;

    // State of the timer core and its bus slave.
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] compare;
        logic [7:0] cmp_buf;
        logic cmp_flag;
        logic ovf_flag;
        logic cmp_mask;
        logic ovf_mask;
        logic async_sel;
        logic [6:0] ctrl;
        logic down;
        logic block;
        logic resp;
        logic [31:0] rdata;
    } tmr8_core_type;

    // State of the clock select and prescaler.
    typedef struct packed {
        logic [1:0] xtal_sync;
        logic xtal_last;
        logic drive;
        logic [9:0] pre;
    } tmr8_clk_type;

    // State of the waveform generator.
    typedef struct packed {
        logic pin;
    } tmr8_wave_type;

    // True for both PWM modes, where the compare value is double buffered.
    function automatic logic tmr8_is_pwm(input tmr8_mode_type m);
        return (m == mode_pwm_pc) || (m == mode_pwm_fast);
    endfunction : tmr8_is_pwm
endpackage : tmr8_pkg
`default_nettype wire

// File: hw/tmr8_regs.svh
`ifndef TMR8_REGS_SVH
`define TMR8_REGS_SVH
// Byte offsets of the registers on the Avalon-MM slave.
`define TMR8_OFS_COUNT 5'h00
`define TMR8_OFS_COMPARE 5'h04
`define TMR8_OFS_FLAG 5'h08
`define TMR8_OFS_MASK 5'h0c
`define TMR8_OFS_ASYNC 5'h10
`define TMR8_OFS_CTRL 5'h14
// Bit positions in the flag and mask registers.
`define TMR8_BIT_CMP 7
`define TMR8_BIT_OVF 6
// Bit position of the asynchronous clock select in the async status register.
`define TMR8_BIT_ASYNC_SEL 3
// Control register fields: clock select, waveform mode, output mode, force.
`define TMR8_CS_MSB 2
`define TMR8_CS_LSB 0
`define TMR8_MODE_MSB 4
`define TMR8_MODE_LSB 3
`define TMR8_COM_MSB 6
`define TMR8_COM_LSB 5
`define TMR8_BIT_FORCE 7
// Counter extremes and reset values.
`define TMR8_VAL_BOTTOM 8'h00
`define TMR8_VAL_MAX 8'hff
`define TMR8_RST_BYTE 8'h00
`define TMR8_RST_CTRL 7'h00
// Prescaler tap masks, one per clock select code.
`define TMR8_TAP_1 10'h000
`define TMR8_TAP_8 10'h007
`define TMR8_TAP_32 10'h01f
`define TMR8_TAP_64 10'h03f
`define TMR8_TAP_128 10'h07f
`define TMR8_TAP_256 10'h0ff
`define TMR8_TAP_1024 10'h3ff
`endif

// File: hw/tmr8_tick_if.sv
`timescale 1ns/1ns
`default_nettype none
// Carries the timer tick and the compare events between the timer's parts.
interface tmr8_tick_if;
    logic tick; // One-cycle timer clock enable.
    logic match_evt; // Unblocked compare match on a tick.
    logic wrap_evt; // Tick on which the counter leaves MAX.
    logic force_evt; // Software forced compare strobe.
    logic down; // Counting direction in phase correct mode.
    tmr8_pkg::tmr8_mode_type mode; // Active waveform mode.
    logic [1:0] com; // Compare output mode.
    modport clk_src(output tick);
    modport wave(input tick, input match_evt, input wrap_evt, input force_evt,
        input down, input mode, input com);
endinterface : tmr8_tick_if
`default_nettype wire

// File: hw/tmr8_timer.sv
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "tmr8_regs.svh"
module tmr8_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic crystal_pin_a,
    output logic crystal_pin_b,
    output logic compare_output_pin,
    output logic compare_output_pin_oe,
    output logic irq_compare_req,
    output logic irq_overflow_req,
    input wire logic irq_compare_ack,
    input wire logic irq_overflow_ack
);
    tmr8_pkg::tmr8_core_type q, n; // Registered state and its next value.
    tmr8_pkg::tmr8_mode_type mode; // Decoded waveform mode.
    logic access; // A bus request is pending.
    logic wr; // A write takes effect on this edge.
    logic [7:0] wd; // Low byte of the write data.
    logic [7:0] rd; // Read value before zero extension.
    logic [7:0] top_val; // Highest value of the count sequence.
    logic match; // Count equals the active compare value.
    logic at_bottom; // Count sits at BOTTOM.
    logic at_max; // Count sits at MAX.
    logic wr_count; // Software writes the count.
    logic wr_compare; // Software writes the compare value.
    logic pwm; // A PWM mode is active.

    tmr8_tick_if tif();

    // Clock select and prescaler; the async select bit steers the source.
    tmr8_clksel u_clksel (
        .clk(clk),
        .rst_n(rst_n),
        .xtal_in(crystal_pin_a),
        .async_sel(q.async_sel),
        .clk_sel(q.ctrl[`TMR8_CS_MSB:`TMR8_CS_LSB]),
        .xtal_drive(crystal_pin_b),
        .bus(tif.clk_src)
    );

    // Waveform generator for the compare output pin.
    tmr8_wavegen u_wavegen (
        .clk(clk),
        .rst_n(rst_n),
        .bus(tif.wave),
        .pin(compare_output_pin),
        .pin_oe(compare_output_pin_oe)
    );

    // Decodes of the current count, used by counter, flags and waveform.
    always_comb
    begin
        mode = tmr8_pkg::tmr8_mode_type'(q.ctrl[`TMR8_MODE_MSB:`TMR8_MODE_LSB]);
        pwm = tmr8_pkg::tmr8_is_pwm(mode);
        match = q.count == q.compare;
        at_bottom = q.count == `TMR8_VAL_BOTTOM;
        at_max = q.count == `TMR8_VAL_MAX;
        top_val = (mode == tmr8_pkg::mode_ctc) ? q.compare : `TMR8_VAL_MAX;
        access = avs_read | avs_write;
        wr = avs_write & q.resp & avs_byteenable[0];
        wd = avs_writedata[7:0];
        wr_count = wr && (avs_address == `TMR8_OFS_COUNT);
        wr_compare = wr && (avs_address == `TMR8_OFS_COMPARE);
    end

    // Read multiplexer; reserved bits and unmapped offsets read as zero.
    always_comb
    begin
        rd = 8'h00;
        case (avs_address)
            `TMR8_OFS_COUNT: rd = q.count;
            `TMR8_OFS_COMPARE: rd = q.cmp_buf;
            `TMR8_OFS_FLAG:
            begin
                rd[`TMR8_BIT_CMP] = q.cmp_flag;
                rd[`TMR8_BIT_OVF] = q.ovf_flag;
            end
            `TMR8_OFS_MASK:
            begin
                rd[`TMR8_BIT_CMP] = q.cmp_mask;
                rd[`TMR8_BIT_OVF] = q.ovf_mask;
            end
            `TMR8_OFS_ASYNC: rd[`TMR8_BIT_ASYNC_SEL] = q.async_sel;
            `TMR8_OFS_CTRL: rd = {1'b0, q.ctrl};
            default: rd = 8'h00;
        endcase
    end

    // Next state: bus slave, register writes, counter and flags.
    always_comb
    begin
        n = q;
        // Every request waits exactly one cycle; read data is captured then.
        n.resp = access & ~q.resp;
        if (access && !q.resp)
        begin
            n.rdata = {24'h000000, rd};
        end
        // Clearing comes first so that a flag set on the same edge wins.
        if (wr && avs_address == `TMR8_OFS_FLAG)
        begin
            if (wd[`TMR8_BIT_CMP])
            begin
                n.cmp_flag = 1'b0;
            end
            if (wd[`TMR8_BIT_OVF])
            begin
                n.ovf_flag = 1'b0;
            end
        end
        if (irq_compare_ack)
        begin
            n.cmp_flag = 1'b0;
        end
        if (irq_overflow_ack)
        begin
            n.ovf_flag = 1'b0;
        end
        if (wr && avs_address == `TMR8_OFS_MASK)
        begin
            n.cmp_mask = wd[`TMR8_BIT_CMP];
            n.ovf_mask = wd[`TMR8_BIT_OVF];
        end
        if (wr && avs_address == `TMR8_OFS_ASYNC)
        begin
            n.async_sel = wd[`TMR8_BIT_ASYNC_SEL];
        end
        if (wr && avs_address == `TMR8_OFS_CTRL)
        begin
            n.ctrl = wd[6:0];
        end
        if (mode != tmr8_pkg::mode_pwm_pc)
        begin
            n.down = 1'b0;
        end
        if (tif.tick)
        begin
            // A count write blocks a match only on the first tick after it.
            n.block = 1'b0;
            if (match && !q.block)
            begin
                n.cmp_flag = 1'b1;
            end
            case (mode)
                tmr8_pkg::mode_pwm_pc:
                begin
                    if (!q.down)
                    begin
                        n.down = at_max;
                        n.count = at_max ? q.count - 8'h01 : q.count + 8'h01;
                    end
                    else
                    begin
                        n.down = !at_bottom;
                        n.count = at_bottom ? q.count + 8'h01 : q.count - 8'h01;
                        if (at_bottom)
                        begin
                            n.ovf_flag = 1'b1;
                        end
                    end
                end
                tmr8_pkg::mode_ctc:
                begin
                    // Reaching TOP restarts the period from BOTTOM.
                    n.count = (q.count == top_val) ? `TMR8_VAL_BOTTOM : q.count + 8'h01;
                    if (at_max)
                    begin
                        n.ovf_flag = 1'b1;
                    end
                end
                default:
                begin
                    n.count = q.count + 8'h01;
                    if (at_max)
                    begin
                        n.ovf_flag = 1'b1;
                    end
                end
            endcase
            // The buffered compare value moves across only at TOP.
            if (pwm && at_max)
            begin
                n.compare = q.cmp_buf;
            end
        end
        if (wr_compare)
        begin
            n.cmp_buf = wd;
            if (!pwm)
            begin
                n.compare = wd;
            end
        end
        // Placed last so a count write overrides any tick on this edge.
        if (wr_count)
        begin
            n.count = wd;
            n.block = 1'b1;
        end
    end

    // Registers the state; everything starts on the I/O clock, stopped.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

    // Events handed to the waveform generator.
    assign tif.match_evt = tif.tick & match & ~q.block;
    assign tif.wrap_evt = tif.tick & at_max;
    assign tif.force_evt = wr && (avs_address == `TMR8_OFS_CTRL) && wd[`TMR8_BIT_FORCE] && !pwm;
    assign tif.down = q.down;
    assign tif.mode = mode;
    assign tif.com = q.ctrl[`TMR8_COM_MSB:`TMR8_COM_LSB];

    assign avs_waitrequest = access & ~q.resp;
    assign avs_readdata = q.rdata;
    assign irq_compare_req = q.cmp_flag & q.cmp_mask;
    assign irq_overflow_req = q.ovf_flag & q.ovf_mask;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_match_flag: assert property (tif.match_evt |=> q.cmp_flag)
        else $error("match did not set flag");
    a_masked_irq: assert property ((tif.match_evt && q.cmp_mask) |=> irq_compare_req)
        else $error("unmasked compare request missing");
    a_write_wins: assert property (wr_count |=> q.count == $past(wd))
        else $error("count write lost");
    a_idle_hold: assert property ((!tif.tick && !wr_count) |=> $stable(q.count))
        else $error("count moved without tick");
    a_step_one: assert property ((tif.tick && mode == tmr8_pkg::mode_normal && !wr_count)
        |=> q.count == 8'($past(q.count) + 8'h01))
        else $error("count did not step by one");
    a_ctc_reload: assert property ((tif.tick && mode == tmr8_pkg::mode_ctc && match && !wr_count)
        |=> q.count == `TMR8_VAL_BOTTOM)
        else $error("no reload on compare");
    a_direct_cmp: assert property ((wr_compare && !pwm) |=> q.compare == $past(wd))
        else $error("compare not written directly");
    a_buf_hold: assert property ((wr_compare && pwm && !(tif.tick && at_max))
        |=> $stable(q.compare))
        else $error("buffered compare leaked");
    a_ovf_max: assert property ((tif.tick && mode == tmr8_pkg::mode_normal && at_max && !wr_count)
        |=> q.ovf_flag && q.count == `TMR8_VAL_BOTTOM)
        else $error("overflow at MAX missing");
    a_one_wait: assert property ((access && avs_waitrequest) |=> !avs_waitrequest)
        else $error("slave waited too long");
    c_match_irq: cover property (tif.match_evt && q.cmp_mask);
    c_ctc_wrap: cover property (tif.tick && mode == tmr8_pkg::mode_ctc && match);
    c_pc_turn: cover property (tif.tick && mode == tmr8_pkg::mode_pwm_pc && q.down && at_bottom);
    c_flag_clear: cover property (wr && avs_address == `TMR8_OFS_FLAG && q.cmp_flag);
endmodule : tmr8_timer
`default_nettype wire

// File: hw/tmr8_wavegen.sv
`timescale 1ns/1ns
`default_nettype none
`include "tmr8_regs.svh"
// Drives the compare output pin from compare events and the waveform mode.
module tmr8_wavegen (
    input wire logic clk,
    input wire logic rst_n,
    tmr8_tick_if.wave bus,
    output logic pin,
    output logic pin_oe
);
    tmr8_pkg::tmr8_wave_type q, n; // Registered output level.

    // Non-PWM modes act on matches and forces; PWM modes set and clear.
    always_comb
    begin
        n = q;
        case (bus.mode)
            tmr8_pkg::mode_pwm_fast:
            begin
                // Clear or set on match, the opposite when the count wraps.
                if (bus.match_evt && bus.com[1])
                begin
                    n.pin = bus.com[0];
                end
                else if (bus.wrap_evt && bus.com[1])
                begin
                    n.pin = ~bus.com[0];
                end
            end
            tmr8_pkg::mode_pwm_pc:
            begin
                // Up-count matches clear, down-count matches set, inverted by com[0].
                if (bus.match_evt && bus.com[1])
                begin
                    n.pin = bus.down ^ bus.com[0];
                end
            end
            default:
            begin
                if (bus.match_evt || bus.force_evt)
                begin
                    case (bus.com)
                        2'h1: n.pin = ~q.pin;
                        2'h2: n.pin = 1'b0;
                        2'h3: n.pin = 1'b1;
                        default: n.pin = q.pin;
                    endcase
                end
            end
        endcase
    end

    // Registers the pin level.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

    assign pin = q.pin;
    // The generator takes the pin only when an output mode is chosen.
    assign pin_oe = bus.com != 2'h0;
endmodule : tmr8_wavegen
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tmr8_regs.svh"
// Self-checking bench for the eight bit timer, its bus and its far side.
module tb;
    localparam logic [4:0] o_cnt = `TMR8_OFS_COUNT; // Count register.
    localparam logic [4:0] o_cmp = `TMR8_OFS_COMPARE; // Compare register.
    localparam logic [4:0] o_flag = `TMR8_OFS_FLAG; // Flag register.
    localparam logic [4:0] o_mask = `TMR8_OFS_MASK; // Mask register.
    localparam logic [4:0] o_async = `TMR8_OFS_ASYNC; // Async status register.
    localparam logic [4:0] o_ctrl = `TMR8_OFS_CTRL; // Control register.
    logic clk = 1'b0; // System clock.
    logic rst_n = 1'b0; // Reset, active low.
    logic [4:0] adr = 5'h00; // Bus address.
    logic rd = 1'b0; // Read request.
    logic wr = 1'b0; // Write request.
    logic [31:0] wdat = 32'h0; // Write data.
    logic [3:0] be = 4'hf; // Byte enables.
    logic [31:0] rdat; // Read data.
    logic wait_req; // Wait request.
    logic xtal, xtal_b, pin, pin_oe, irq_c, irq_o, ack_c, ack_o; // Pins.
    logic xtal_en = 1'b0; // Crystal running.
    logic svc_en = 1'b0; // CPU services requests.
    int num_errors = 0;
    int n_tests = 0;
    logic [31:0] v; // Last value read.

    tmr8_timer tmr8_timer_inst (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
        .avs_waitrequest(wait_req), .crystal_pin_a(xtal), .crystal_pin_b(xtal_b),
        .compare_output_pin(pin), .compare_output_pin_oe(pin_oe), .irq_compare_req(irq_c),
        .irq_overflow_req(irq_o), .irq_compare_ack(ack_c), .irq_overflow_ack(ack_o));
    tmr8_far_model tmr8_far_model_inst (.clk(clk), .rst_n(rst_n), .xtal_en(xtal_en),
        .svc_en(svc_en), .irq_compare_req(irq_c), .irq_overflow_req(irq_o),
        .crystal_pin_a(xtal), .irq_compare_ack(ack_c), .irq_overflow_ack(ack_o));

    // The clock toggles every half period of 5 ns.
    always #5 clk = ~clk;

    // Compares a value; case inequality so an unknown never passes.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : chk

    // Bus write held until wait request is seen low at a rising edge.
    task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wdat <= d;
        wr <= 1'b1;
        do @(posedge clk); while (wait_req !== 1'b0);
        wr <= 1'b0;
    endtask : bus_wr

    // Bus read; data is taken at the same edge that ends the wait.
    task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        adr <= a;
        rd <= 1'b1;
        do @(posedge clk); while (wait_req !== 1'b0);
        d = rdat;
        rd <= 1'b0;
    endtask : bus_rd

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // Every register reads zero after reset, and so does an unmapped place.
    task automatic t_reset();
        for (int k = 0; k < 7; k++)
        begin
            bus_rd(5'(k * 4), v);
            chk("reset value", 32'h0, v);
        end
    endtask : t_reset

    // A stopped timer keeps its count; only the low byte is stored.
    task automatic t_stopped();
        be <= 4'he;
        bus_wr(o_cnt, 32'h11);
        be <= 4'hf;
        bus_rd(o_cnt, v);
        chk("masked byte write", 32'h0, v);
        bus_wr(o_cnt, 32'hffff_ff5a);
        repeat (20) @(posedge clk);
        bus_rd(o_cnt, v);
        chk("stopped count", 32'h5a, v);
    endtask : t_stopped

    // Run through a match and a wrap, then mask, clear and service the flags.
    task automatic t_overflow();
        int k;
        bus_wr(o_cmp, 32'hf8);
        bus_wr(o_cnt, 32'hf0);
        bus_wr(o_mask, 32'hc0);
        bus_wr(o_ctrl, 32'h01);
        k = 0;
        while (irq_o !== 1'b1 && k < 400)
        begin
            @(posedge clk);
            k++;
        end
        bus_wr(o_ctrl, 32'h00);
        chk("overflow request", 32'h1, irq_o);
        bus_rd(o_flag, v);
        chk("flags after wrap", 32'hc0, v);
        chk("compare request", 32'h1, irq_c);
        bus_wr(o_mask, 32'h40);
        repeat (2) @(posedge clk);
        chk("masked compare request", 32'h0, irq_c);
        chk("overflow request kept", 32'h1, irq_o);
        bus_wr(o_flag, 32'h80);
        bus_rd(o_flag, v);
        chk("flag after write one", 32'h40, v);
        svc_en <= 1'b1;
        repeat (4) @(posedge clk);
        svc_en <= 1'b0;
        bus_rd(o_flag, v);
        chk("flag after service", 32'h0, v);
        bus_wr(o_mask, 32'h00);
    endtask : t_overflow

    // A count write wins over counting and blocks the match on the next tick.
    task automatic t_block();
        bus_wr(o_cmp, 32'h05);
        bus_wr(o_ctrl, 32'h01);
        bus_wr(o_cnt, 32'h80);
        bus_wr(o_ctrl, 32'h00);
        bus_rd(o_cnt, v);
        chk("count after live write", 32'h1, v >= 32'h80 && v <= 32'h84);
        bus_wr(o_cnt, 32'h05);
        bus_wr(o_flag, 32'hc0);
        bus_wr(o_ctrl, 32'h01);
        repeat (30) @(posedge clk);
        bus_wr(o_ctrl, 32'h00);
        bus_rd(o_flag, v);
        chk("blocked match", 32'h0, v);
    endtask : t_block

    // Clear on compare keeps the count at or below the compare value.
    // Phase correct mode turns at MAX without an overflow, unlike normal mode.
    task automatic t_ctc();
        bus_wr(o_cmp, 32'h10);
        bus_wr(o_cnt, 32'h00);
        bus_wr(o_flag, 32'hc0);
        bus_wr(o_ctrl, 32'h11);
        repeat (100) @(posedge clk);
        bus_wr(o_ctrl, 32'h10);
        bus_rd(o_cnt, v);
        chk("reloaded count", 32'h1, v <= 32'h10);
        bus_rd(o_flag, v);
        chk("reload flags", 32'h80, v);
        bus_wr(o_ctrl, 32'h08);
        bus_wr(o_cnt, 32'hfc);
        bus_wr(o_flag, 32'hc0);
        bus_wr(o_ctrl, 32'h09);
        repeat (12) @(posedge clk);
        bus_wr(o_ctrl, 32'h08);
        bus_rd(o_cnt, v);
        chk("turned count", 32'h1, v >= 32'he8 && v <= 32'hfe);
        bus_rd(o_flag, v);
        chk("no overflow at MAX", 32'h0, v);
    endtask : t_ctc

    // In fast PWM a new compare waits for MAX; in normal mode it acts at once.
    task automatic t_pwm();
        logic [31:0] m;
        for (int k = 0; k < 2; k++)
        begin
            m = (k == 0) ? 32'h18 : 32'h00;
            bus_wr(o_ctrl, m);
            bus_wr(o_cmp, 32'h22);
            bus_rd(o_cmp, v);
            chk("compare readback", 32'h22, v);
            bus_wr(o_cnt, 32'h20);
            bus_wr(o_flag, 32'hc0);
            bus_wr(o_ctrl, m | 32'h01);
            repeat (20) @(posedge clk);
            bus_wr(o_ctrl, m);
            bus_rd(o_flag, v);
            chk("buffered compare", (k == 0) ? 32'h0 : 32'h80, v);
        end
    endtask : t_pwm

    // The crystal drives the count only once asynchronous select is set.
    task automatic t_async();
        bus_wr(o_cnt, 32'h00);
        bus_wr(o_async, 32'h08);
        bus_rd(o_async, v);
        chk("async select", 32'h08, v);
        bus_wr(o_ctrl, 32'h01);
        repeat (20) @(posedge clk);
        bus_rd(o_cnt, v);
        chk("no io clock ticks", 32'h0, v);
        chk("amplifier drive", 32'h1, xtal_b);
        xtal_en <= 1'b1;
        repeat (200) @(posedge clk);
        xtal_en <= 1'b0;
        bus_wr(o_ctrl, 32'h00);
        bus_rd(o_cnt, v);
        chk("crystal ticks", 32'h1, v >= 32'd18 && v <= 32'd26);
        bus_wr(o_async, 32'h00);
    endtask : t_async

    // Toggle mode with the force strobe flips the output pin each time.
    task automatic t_force();
        bus_wr(o_ctrl, 32'h20);
        repeat (2) @(posedge clk);
        chk("pin enable", 32'h1, pin_oe);
        chk("pin idle", 32'h0, pin);
        bus_wr(o_ctrl, 32'ha0);
        repeat (2) @(posedge clk);
        chk("pin toggled", 32'h1, pin);
        bus_wr(o_ctrl, 32'ha0);
        repeat (2) @(posedge clk);
        chk("pin toggled back", 32'h0, pin);
    endtask : t_force

    // Main sequence: reset for 20 cycles, then every scenario in turn.
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_stopped();
        t_overflow();
        t_block();
        t_ctc();
        t_pwm();
        t_async();
        t_force();
        final_report();
    end

    // The tests need under a thousand cycles; twenty times that means a hang.
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        final_report();
    end
endmodule : tb
`default_nettype wire

// File: testbench/tmr8_far_model.sv
`timescale 1ns/1ns
`default_nettype none
// Stands in for the watch crystal and for the CPU that services the timer interrupts.
module tmr8_far_model #(
    parameter int xtal_half = 43 // Half period in ns, far shorter than a watch crystal to keep runs brief.
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic xtal_en,
    input wire logic svc_en,
    input wire logic irq_compare_req,
    input wire logic irq_overflow_req,
    output logic crystal_pin_a,
    output logic irq_compare_ack,
    output logic irq_overflow_ack
);
    // The oscillator runs from its own time base, unrelated in phase to clk.
    // It rests low while disabled, so a stopped crystal never makes a stray edge.
    // One process owns the pin, so it has a single driver from time zero on.
    initial
    begin
        crystal_pin_a = 1'b0;
        forever
        begin
            #xtal_half;
            crystal_pin_a = xtal_en ? ~crystal_pin_a : 1'b0;
        end
    end

    // Entering a handler acknowledges the pending request once; the pulse ends at once.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_compare_ack <= 1'b0;
            irq_overflow_ack <= 1'b0;
        end
        else
        begin
            irq_compare_ack <= svc_en & irq_compare_req & ~irq_compare_ack;
            irq_overflow_ack <= svc_en & irq_overflow_req & ~irq_overflow_ack;
        end
    end
endmodule : tmr8_far_model
`default_nettype wire
